// >>> codec_interrupt_flag_routing.sv
// Live status, sticky flags and two pulsed interrupt outputs of the audio codec.
`timescale 1ns/1ps
`include "codec_irq_defs.svh"
// Overview of the block:
// Two live status bytes mirror the event sources as they stand each cycle.
// Apart from the reserved ADC bits, the headset presence bit is the only live bit stored here; it
// follows the one-cycle insertion and removal detection pulses.
// Every live DAC condition and ADC bits 6, 4 and 3 set a sticky flag when they
// rise; the DC result bit (ADC bit 2) has none. A read of the sticky register
// clears it, except for any flag whose condition rises in the same cycle.
// Two enable registers route the seven event classes onto the two pins.
// Bit 0 of each enable register selects a single pulse or a pulse train.
// A train keeps running until the two sticky registers here and the
// flag register held elsewhere have all been read after the last event.
// Pulse width and period are counted in ticks of a slow timebase so that
// the typical durations can be matched to whatever clock drives the block.
// Hazards and limits:
// The first tick of a pulse may come early, so a pulse can be up to one
// tick shorter than the nominal width.
// A single-mode event that arrives during a pulse is remembered once only.
// While the clock enable is low every register, including the read data
// and the timebase, holds its value.
module codec_interrupt_flag_routing
  import codec_irq_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_NS / `MCLK_PERIOD_NS,
  parameter int PULSE_TICKS = `PULSE_MS,
  parameter int PERIOD_TICKS = `PERIOD_MS
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic shortLeft,
  input wire logic shortRight,
  input wire logic buttonPressed,
  input wire logic headsetInsertDet,
  input wire logic headsetRemoveDet,
  input wire logic drcLeftAbove,
  input wire logic drcRightAbove,
  input wire logic playStdPort,
  input wire logic playAuxPort,
  input wire logic agcNoiseBelow,
  input wire logic recStdPort,
  input wire logic recAuxPort,
  input wire logic dcMeasReady,
  input wire logic sarFlagsRead,
  output logic firstInterruptOutput,
  output logic secondInterruptOutput
);

  // Refuse timing values the counters cannot serve
  initial begin
    if (TICK_CYCLES < 1 || PULSE_TICKS < 1 || PERIOD_TICKS <= PULSE_TICKS || PERIOD_TICKS > 255) begin
      $error("codec_interrupt_flag_routing: bad timing parameters");
    end
  end

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1); // Prescaler wrap value
  localparam logic [7:0] PULSE_LAST = 8'(PULSE_TICKS - 1); // Last tick of a high phase
  localparam logic [7:0] PERIOD_LAST = 8'(PERIOD_TICKS - 1); // Last tick of a whole period

  byte_t dacLive; // Live DAC status byte
  byte_t adcLive; // Live ADC status byte
  byte_t dacPrev_q; // Previous live DAC byte for edge detection
  byte_t adcPrev_q; // Previous live ADC byte for edge detection
  byte_t dacRise; // New DAC conditions this cycle
  byte_t adcRise; // New ADC conditions this cycle
  byte_t dacSticky_q; // Sticky DAC flags
  byte_t adcSticky_q; // Sticky ADC flags
  byte_t adcRsv_q; // Reserved read/write bits of the live ADC register
  byte_t firstEn_q; // First output routing and mode
  byte_t secondEn_q; // Second output routing and mode
  byte_t rdata_q; // Read data register
  logic presence_q; // Headset present
  logic [7:1] events; // Per-source new events, aligned with enable bits
  logic [2:0] readSeen_q; // Flag registers read since the last event
  logic allRead; // Every flag register has been read
  logic [31:0] tickCnt_q; // Timebase prescaler
  logic tick_q; // One-cycle slow timebase strobe
  logic [1:0] irqOut_q; // Interrupt output flip-flops
  logic rdDac; // Read of the sticky DAC register
  logic rdAdc; // Read of the sticky ADC register

  // Assemble the live status bytes
  always_comb begin
    dacLive = {shortLeft, shortRight, buttonPressed, presence_q,
               drcLeftAbove, drcRightAbove, playStdPort, playAuxPort}; // [RL1] [RL2] [RL3] [RL4] [RL5] [RL6]
    adcLive = adcRsv_q & `ADC_RSV_MASK;
    adcLive[6] = agcNoiseBelow; // [RL7]
    adcLive[4] = recStdPort; // [RL8]
    adcLive[3] = recAuxPort; // [RL8]
    adcLive[2] = dcMeasReady; // [RL9]
  end

  // Rising conditions and source events
  always_comb begin
    dacRise = dacLive & ~dacPrev_q;
    adcRise = adcLive & ~adcPrev_q & `ADC_STICKY_MASK;
    events[`BIT_INSERT] = headsetInsertDet | headsetRemoveDet;
    events[`BIT_BUTTON] = dacRise[5];
    events[`BIT_DRC] = dacRise[3] | dacRise[2];
    events[`BIT_AGC] = adcRise[6];
    events[`BIT_SHORT] = dacRise[7] | dacRise[6];
    events[`BIT_ENGINE] = dacRise[1] | dacRise[0] | adcRise[4] | adcRise[3];
    events[`BIT_DCMEAS] = dcMeasReady & ~adcPrev_q[2];
  end

  // Reads of the sticky registers clear them and count towards stopping a train
  assign rdDac = regRd && regAddr == `OFS_DAC_STICKY;
  // The ADC sticky register counts the same way
  assign rdAdc = regRd && regAddr == `OFS_ADC_STICKY;
  // A train may stop only once all three flag reads have been seen
  assign allRead = &readSeen_q;

  // Edge detection history
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dacPrev_q <= 8'h00;
      adcPrev_q <= 8'h00;
    end else if (clkEn) begin
      dacPrev_q <= dacLive;
      adcPrev_q <= adcLive;
    end
  end

  // Headset presence follows insertion and removal detection
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      presence_q <= 1'b0;
    end else if (clkEn) begin
      if (headsetInsertDet) begin
        presence_q <= 1'b1; // [RL4]
      end else if (headsetRemoveDet) begin
        presence_q <= 1'b0; // [RL4]
      end
    end
  end

  // Sticky flags: a new condition wins over a clearing read
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dacSticky_q <= 8'h00;
      adcSticky_q <= 8'h00;
    end else if (clkEn) begin
      dacSticky_q <= (rdDac ? 8'h00 : dacSticky_q) | dacRise; // [RL18]
      adcSticky_q <= (rdAdc ? 8'h00 : adcSticky_q) | adcRise; // [RL18]
    end
  end

  // Software-written registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      firstEn_q <= `EN_RESET;
      secondEn_q <= `EN_RESET;
      adcRsv_q <= 8'h00;
    end else if (clkEn && regWr) begin
      case (regAddr)
        `OFS_FIRST_EN: begin
          firstEn_q <= regWdata; // [RL11] [RL12]
        end
        `OFS_SECOND_EN: begin
          secondEn_q <= regWdata; // [RL15]
        end
        `OFS_ADC_LIVE: begin
          // Only the reserved bits store; software keeps the low pair at zero
          adcRsv_q <= regWdata & `ADC_RSV_MASK; // [RL10]
        end
        default: begin
          // Writes elsewhere are ignored
        end
      endcase
    end
  end

  // Read data, valid in the cycle after the read strobe
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (clkEn) begin
      if (regRd) begin
        case (regAddr)
          `OFS_DAC_STICKY: begin
            rdata_q <= dacSticky_q;
          end
          `OFS_ADC_STICKY: begin
            rdata_q <= adcSticky_q;
          end
          `OFS_DAC_LIVE: begin
            rdata_q <= dacLive;
          end
          `OFS_ADC_LIVE: begin
            rdata_q <= adcLive;
          end
          `OFS_FIRST_EN: begin
            rdata_q <= firstEn_q;
          end
          `OFS_SECOND_EN: begin
            rdata_q <= secondEn_q;
          end
          default: begin
            rdata_q <= 8'h00; // Unmapped reads return zero
          end
        endcase
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  // Track reads of the three flag registers; a new event restarts tracking
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      readSeen_q <= 3'h0;
    end else if (clkEn) begin
      if (|events) begin
        readSeen_q <= 3'h0;
      end else begin
        readSeen_q <= readSeen_q | {sarFlagsRead, rdAdc, rdDac}; // [RL14] [RL17] [RL18]
      end
    end
  end

  // Slow timebase strobe
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tickCnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else if (clkEn) begin
      if (tickCnt_q >= TICK_LAST) begin
        tickCnt_q <= 32'h0;
        tick_q <= 1'b1; // [RL20]
      end else begin
        tickCnt_q <= tickCnt_q + 32'h1;
        tick_q <= 1'b0;
      end
    end
  end

  // One pulse generator per interrupt output
  for (genvar g = 0; g < 2; g++) begin : genPulse
    byte_t en; // Routing and mode for this output
    logic trigger; // An enabled source has a new event
    logic repeatMode; // Pulse train instead of single pulse
    pulse_state_e state_q; // Generator state
    logic [7:0] ticks_q; // Ticks elapsed in the current period
    logic again_q; // Event seen while a single pulse was running

    assign en = (g == 0) ? firstEn_q : secondEn_q;
    assign trigger = |(events & en[7:1]); // [RL11] [RL12] [RL15] [RL19]
    assign repeatMode = en[`BIT_REPEAT];

    // Pulse sequencing on the slow timebase
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        state_q <= PG_IDLE;
        ticks_q <= 8'h00;
        again_q <= 1'b0;
        irqOut_q[g] <= 1'b0;
      end else if (clkEn) begin
        case (state_q)
          PG_IDLE: begin
            again_q <= 1'b0;
            if (trigger) begin
              state_q <= PG_HIGH; // [RL19]
              ticks_q <= 8'h00;
              irqOut_q[g] <= 1'b1;
            end else begin
              irqOut_q[g] <= 1'b0; // Low while nothing is pending
            end
          end
          PG_HIGH: begin
            if (trigger) begin
              again_q <= 1'b1;
            end
            if (tick_q) begin
              ticks_q <= ticks_q + 8'h01;
              if (ticks_q == PULSE_LAST) begin
                state_q <= PG_LOW; // [RL13] [RL16]
                irqOut_q[g] <= 1'b0;
              end
            end
          end
          PG_LOW: begin
            if (repeatMode) begin
              if (allRead && !trigger) begin
                state_q <= PG_IDLE; // [RL14] [RL17]
              end else if (tick_q && ticks_q == PERIOD_LAST) begin
                state_q <= PG_HIGH; // [RL14] [RL17]
                ticks_q <= 8'h00;
                irqOut_q[g] <= 1'b1;
              end else if (tick_q) begin
                ticks_q <= ticks_q + 8'h01;
              end
            end else if (again_q || trigger) begin
              // An event during the last pulse gets its own pulse after the gap
              if (tick_q && ticks_q == PERIOD_LAST) begin
                state_q <= PG_HIGH; // [RL13] [RL16]
                ticks_q <= 8'h00;
                again_q <= 1'b0;
                irqOut_q[g] <= 1'b1;
              end else begin
                again_q <= 1'b1;
                if (tick_q) begin
                  ticks_q <= ticks_q + 8'h01;
                end
              end
            end else begin
              state_q <= PG_IDLE; // [RL13] [RL16]
            end
          end
          default: begin
            state_q <= PG_IDLE;
            irqOut_q[g] <= 1'b0;
          end
        endcase
      end
    end
  end

  // Outputs come straight from flip-flops, so the pins never glitch
  assign regRdata = rdata_q;
  // First pin
  assign firstInterruptOutput = irqOut_q[0];
  // Second pin
  assign secondInterruptOutput = irqOut_q[1];

endmodule

// >>> codec_irq_defs.svh
// Register offsets, field positions, reset values and timing for the codec interrupt routing block.
// Operation
// RL1: Live DAC bit 7 shows left short circuit.
// RL2: Live DAC bit 6 shows right short circuit.
// RL3: Live DAC bit 5 shows button held.
// RL4: Live DAC bit 4 shows headset presence.
// RL5: Live DAC bits 3,2 show compression threshold exceeded.
// RL6: Live DAC bits 1,0 mirror playback engine ports.
// RL7: Live ADC bit 6 shows record below noise.
// RL8: Live ADC bits 4,3 mirror record engine ports.
// RL9: Live ADC bit 2 shows DC result available.
// RL10: Software writes zeros to low reserved bits.
// RL11: First control bits 7..4 enable four sources.
// RL12: First control bits 3..1 enable three sources.
// RL13: First bit 0 clear gives one pulse.
// RL14: First bit 0 set repeats until flags read.
// RL15: Second control register routes same seven sources.
// RL16: Second bit 0 clear gives one pulse.
// RL17: Second bit 0 set repeats until flags read.
// RL18: Sticky flags clear on read, set again.
// RL19: Any enabled new event starts a pulse.
// RL20: Pulse timing counts a slow internal timebase.
`ifndef CODEC_IRQ_DEFS_SVH
`define CODEC_IRQ_DEFS_SVH
`define OFS_DAC_STICKY 8'h2C
`define OFS_ADC_STICKY 8'h2D
`define OFS_DAC_LIVE 8'h2E
`define OFS_ADC_LIVE 8'h2F
`define OFS_FIRST_EN 8'h30
`define OFS_SECOND_EN 8'h31
`define EN_RESET 8'h00
`define ADC_RSV_MASK 8'hA3
`define ADC_STICKY_MASK 8'h58
`define BIT_INSERT 7
`define BIT_BUTTON 6
`define BIT_DRC 5
`define BIT_AGC 4
`define BIT_SHORT 3
`define BIT_ENGINE 2
`define BIT_DCMEAS 1
`define BIT_REPEAT 0
`define MCLK_PERIOD_NS 50
`define TICK_NS 1000000
`define PULSE_MS 2
`define PERIOD_MS 4
`endif

// >>> codec_irq_pkg.sv
// Types shared by the codec interrupt routing block.
package codec_irq_pkg;
  // Per-output pulse generator states
  typedef enum logic [1:0] {
    PG_IDLE,
    PG_HIGH,
    PG_LOW
  } pulse_state_e;
  // Register byte
  typedef logic [7:0] byte_t;
endpackage

// >>> codec_interrupt_flag_routing_checker.sv
// Port-level assertions for the codec interrupt routing block.
`timescale 1ns/1ps
module codec_irq_checker #(
  parameter int TICK_CYCLES = 4,
  parameter int PULSE_TICKS = 2,
  parameter int PERIOD_TICKS = 4
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic shortLeft,
  input wire logic shortRight,
  input wire logic buttonPressed,
  input wire logic drcLeftAbove,
  input wire logic drcRightAbove,
  input wire logic playStdPort,
  input wire logic playAuxPort,
  input wire logic agcNoiseBelow,
  input wire logic recStdPort,
  input wire logic recAuxPort,
  input wire logic dcMeasReady,
  input wire logic firstInterruptOutput,
  input wire logic secondInterruptOutput
);
  logic [7:0] liveDac; // Live DAC view, presence bit left out
  logic [7:0] liveAdc; // Live ADC view, reserved bits left out
  logic [7:0] firstEnQ; // Shadow of the first enable register
  logic [7:0] secondEnQ; // Shadow of the second enable register
  assign liveDac = {shortLeft, shortRight, buttonPressed, 1'b0, drcLeftAbove, drcRightAbove, playStdPort, playAuxPort};
  assign liveAdc = {1'b0, agcNoiseBelow, 1'b0, recStdPort, recAuxPort, dcMeasReady, 2'b00};
  // Follow enable writes so the checks know what is routed
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      firstEnQ <= 8'h00;
      secondEnQ <= 8'h00;
    end else if (clkEn && regWr) begin
      if (regAddr == 8'h30) firstEnQ <= regWdata;
      if (regAddr == 8'h31) secondEnQ <= regWdata;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  live_dac_read_a: assert property ($past(regRd) && $past(regAddr) == 8'h2E && $past(liveDac) == $past(liveDac, 2)
    |-> (regRdata & 8'hEF) == $past(liveDac)) else $error("live DAC read wrong");
  live_adc_read_a: assert property ($past(regRd) && $past(regAddr) == 8'h2F && $past(liveAdc) == $past(liveAdc, 2)
    |-> (regRdata & 8'h5C) == $past(liveAdc)) else $error("live ADC read wrong");
  unmapped_read_a: assert property ($past(regRd) && ($past(regAddr) < 8'h2C || $past(regAddr) > 8'h31)
    |-> regRdata == 8'h00) else $error("unmapped read not zero");
  first_cause_a: assert property ($rose(firstInterruptOutput) |-> $past(firstEnQ[7:1]) != 7'h00)
    else $error("first pin rose with nothing enabled");
  second_cause_a: assert property ($rose(secondInterruptOutput) |-> $past(secondEnQ[7:1]) != 7'h00)
    else $error("second pin rose with nothing enabled");
  first_width_a: assert property ($rose(firstInterruptOutput) |=> firstInterruptOutput [*3] ##[1:9] !firstInterruptOutput)
    else $error("first pulse width off");
  second_width_a: assert property ($rose(secondInterruptOutput) |=> secondInterruptOutput [*3] ##[1:9] !secondInterruptOutput)
    else $error("second pulse width off");
  short_response_a: assert property ($rose(shortLeft) && clkEn && firstEnQ[3] && !firstEnQ[0] && !firstInterruptOutput
    |=> firstInterruptOutput) else $error("short event gave no pulse");
  button_response_a: assert property ($rose(buttonPressed) && clkEn && secondEnQ[6] && !secondEnQ[0] && !secondInterruptOutput
    |=> secondInterruptOutput) else $error("button event gave no pulse");
endmodule
bind codec_interrupt_flag_routing codec_irq_checker #(
  .TICK_CYCLES(TICK_CYCLES), .PULSE_TICKS(PULSE_TICKS), .PERIOD_TICKS(PERIOD_TICKS)) i_chk (
  .mclk(mclk),
  .resetn(resetn),
  .clkEn(clkEn),
  .regAddr(regAddr),
  .regWdata(regWdata),
  .regWr(regWr),
  .regRd(regRd),
  .regRdata(regRdata),
  .shortLeft(shortLeft),
  .shortRight(shortRight),
  .buttonPressed(buttonPressed),
  .drcLeftAbove(drcLeftAbove),
  .drcRightAbove(drcRightAbove),
  .playStdPort(playStdPort),
  .playAuxPort(playAuxPort),
  .agcNoiseBelow(agcNoiseBelow),
  .recStdPort(recStdPort),
  .recAuxPort(recAuxPort),
  .dcMeasReady(dcMeasReady),
  .firstInterruptOutput(firstInterruptOutput),
  .secondInterruptOutput(secondInterruptOutput)
);

// >>> irq_host_model.sv
// Host side: counts pulses arriving on both interrupt pins.
`timescale 1ns/1ps
module irq_host_model (
  input wire logic mclk,
  input wire logic firstIrq,
  input wire logic secondIrq,
  output int nFirst,
  output int nSecond
);
  logic firstPrevQ = 1'b0; // Last seen first pin level
  logic secondPrevQ = 1'b0; // Last seen second pin level
  // The counts start at zero as int variables do; only the process below writes them
  // A rising pin level is one pulse taken by the host
  always @(posedge mclk) begin
    if (firstIrq && !firstPrevQ) nFirst <= nFirst + 1;
    if (secondIrq && !secondPrevQ) nSecond <= nSecond + 1;
    firstPrevQ <= firstIrq;
    secondPrevQ <= secondIrq;
  end
endmodule

// >>> codec_interrupt_flag_routing_bench.sv
// Self-checking bench for the codec interrupt routing block.
`timescale 1ns/1ps
module codec_interrupt_flag_routing_bench;
  import codec_irq_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic clkEn = 1'b1; // Clock enable; low must freeze the block
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic [13:0] src = 14'h0000; // Event sources, one bit per input
  byte_t regRdata;
  logic firstIrq;
  logic secondIrq;
  int nFirst, nSecond, f0, s0;
  int nMismatch = 0;
  int samplesChecked = 0;
  int srcIx [11] = '{0, 1, 2, 5, 6, 7, 8, 9, 10, 11, 12}; // Live source per entry
  int bitIx [11] = '{7, 6, 5, 3, 2, 1, 0, 6, 4, 3, 2}; // Its status bit
  int enSrc [8] = '{13, 12, 8, 1, 9, 5, 2, 3}; // Source per enable bit
  always #25 mclk = ~mclk;
  codec_interrupt_flag_routing #(.TICK_CYCLES(4), .PULSE_TICKS(2), .PERIOD_TICKS(4)) i_dut (
    .mclk(mclk), .resetn(resetn), .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .shortLeft(src[0]), .shortRight(src[1]),
    .buttonPressed(src[2]), .headsetInsertDet(src[3]), .headsetRemoveDet(src[4]), .drcLeftAbove(src[5]),
    .drcRightAbove(src[6]), .playStdPort(src[7]), .playAuxPort(src[8]), .agcNoiseBelow(src[9]),
    .recStdPort(src[10]), .recAuxPort(src[11]), .dcMeasReady(src[12]), .sarFlagsRead(src[13]),
    .firstInterruptOutput(firstIrq), .secondInterruptOutput(secondIrq));
  irq_host_model i_host (.mclk(mclk), .firstIrq(firstIrq), .secondIrq(secondIrq), .nFirst(nFirst), .nSecond(nSecond));
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  // Read data stand in the cycle after the strobe; mask picks the bits judged
  task rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] mask);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    chk($sformatf("register %h", a), exp & mask, regRdata & mask);
  endtask
  task pulseSrc(input int i);
    @(posedge mclk);
    src[i] <= 1'b1;
    @(posedge mclk);
    src[i] <= 1'b0;
  endtask
  task giveVerdict;
    $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    rd(8'h30, 8'h00, 8'hFF);
    rd(8'h31, 8'h00, 8'hFF);
    rd(8'h2E, 8'h00, 8'hFF);
    rd(8'h2F, 8'h00, 8'hFF);
    @(posedge mclk);
    clkEn <= 1'b0;
    wr(8'h30, 8'hFF);
    clkEn <= 1'b1;
    rd(8'h30, 8'h00, 8'hFF);
    wr(8'h30, 8'hA5);
    rd(8'h30, 8'hA5, 8'hFF);
    wr(8'h31, 8'h5A);
    rd(8'h31, 8'h5A, 8'hFF);
    wr(8'h2F, 8'hA0);
    rd(8'h2F, 8'hA0, 8'hFF);
    wr(8'h2F, 8'h00);
    wr(8'h2E, 8'hFF);
    rd(8'h2E, 8'h00, 8'hFF);
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h00, 8'hFF);
    wr(8'h30, 8'h00);
    wr(8'h31, 8'h00);
    for (int k = 0; k < 11; k++) begin
      @(posedge mclk);
      src[srcIx[k]] <= 1'b1;
      rd(k < 7 ? 8'h2E : 8'h2F, 8'(1 << bitIx[k]), k < 7 ? 8'hEF : 8'h5C);
      @(posedge mclk);
      src[srcIx[k]] <= 1'b0;
    end
    pulseSrc(3);
    rd(8'h2E, 8'h10, 8'h10);
    pulseSrc(4);
    rd(8'h2E, 8'h00, 8'h10);
    for (int b = 1; b < 8; b++) begin
      wr(8'h30, 8'(1 << b));
      wr(8'h31, 8'(1 << b));
      f0 = nFirst;
      s0 = nSecond;
      pulseSrc(enSrc[b]);
      repeat (30) @(posedge mclk);
      chk("first pulses", 8'h01, 8'(nFirst - f0));
      chk("second pulses", 8'h01, 8'(nSecond - s0));
    end
    wr(8'h30, 8'h0C);
    wr(8'h31, 8'h00);
    f0 = nFirst;
    s0 = nSecond;
    pulseSrc(0);
    pulseSrc(7);
    repeat (40) @(posedge mclk);
    chk("merged pulses", 8'h02, 8'(nFirst - f0));
    chk("masked pulses", 8'h00, 8'(nSecond - s0));
    rd(8'h2C, 8'h00, 8'h00);
    rd(8'h2D, 8'h00, 8'h00);
    wr(8'h30, 8'h09);
    wr(8'h31, 8'h09);
    f0 = nFirst;
    s0 = nSecond;
    pulseSrc(0);
    repeat (64) @(posedge mclk);
    chk("first train", 8'h01, 8'(nFirst - f0 >= 3));
    chk("second train", 8'h01, 8'(nSecond - s0 >= 3));
    rd(8'h2C, 8'h80, 8'hFF);
    rd(8'h2C, 8'h00, 8'hFF);
    rd(8'h2D, 8'h00, 8'hFF);
    pulseSrc(13);
    repeat (40) @(posedge mclk);
    f0 = nFirst;
    s0 = nSecond;
    repeat (64) @(posedge mclk);
    chk("first after reads", 8'h00, 8'(nFirst - f0));
    chk("second after reads", 8'h00, 8'(nSecond - s0));
    giveVerdict();
  end
  initial begin
    #1000000;
    nMismatch++;
    giveVerdict();
  end
endmodule
